// ### spc_sysref_ctrl.sv
// SYSREF pulse controller with AXI4-Lite registers.
// Assumes one 200 MHz clock; the SYSREF-rate clock is derived inside.
//
// What this block does
// - Counted mode emits 1 to 255 pulses.
// - Continuous mode: steady train or pulse/pause pattern.
// - Start from trigger pin or software bit.
// - Pin start sense: rise, fall, high, low.
// - Software start on bit rising zero to one.
// - Time-of-day compare match also starts output.
// - Counted mode ends itself after last pulse.
// - Continuous stops on pin edge (level in level modes) or software.
// - Software stop on bit falling one to zero.
// - Stop aligned to SYSREF clock, no runt pulse.
// - One SYSREF rate; device clocks integer multiples.
// - SYSREF and device clock rise together by default.
// - Device clock phase steps; fine delay 0/50/100ps.
// - Per-DPLL delay adjust in 10 ps steps.
// - Up to six SYSREF and device clock pairs.
// - Primary retimes trigger onto trigger output.
// - Secondaries start on the following SYSREF edge.
// - Primary drops trigger output 1.5 periods after a counted burst.
// - Level mode, continuous primary: trigger output follows input per edge.
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`include "spc_consts.svh"
module spc_sysref_ctrl
  import spc_pkg::*;
#(
  parameter int NUM_PAIRS = 6
) (
  // Clock and reset.
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite write address and data.
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [7:0]             awaddr,
  input  wire logic [2:0]             awprot,
  input  wire logic                   wvalid,
  output logic                        wready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  // AXI4-Lite write response.
  output logic                        bvalid,
  input  wire logic                   bready,
  output logic [1:0]                  bresp,
  // AXI4-Lite read.
  input  wire logic                   arvalid,
  output logic                        arready,
  input  wire logic [7:0]             araddr,
  input  wire logic [2:0]             arprot,
  output logic                        rvalid,
  input  wire logic                   rready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  // Trigger pins.
  input  wire logic                   external_async_trigger,
  output logic                        trigger_out,
  // Clock outputs and delay settings.
  output logic                        sysref_clk_int,
  output logic [NUM_PAIRS-1:0]        sysref_out,
  output logic [NUM_PAIRS-1:0]        devclk_out,
  output logic [2*NUM_PAIRS-1:0]      sysref_fine_dly,
  output logic [2*NUM_PAIRS-1:0]      devclk_fine_dly,
  output logic [31:0]                 dpll_delay_steps
);
  typedef struct packed {
    spc_state_t                           state;
    logic [15:0]                          cnt;
    logic                                 clk_int;
    logic                                 emit;
    logic                                 trig_out;
    logic [7:0]                           left;
    logic [2:0]                           slot;
    logic [16:0]                          hold;
    logic                                 start_pend;
    logic                                 stop_pend;
    logic                                 sync1;
    logic                                 sync2;
    logic                                 sync3;
    logic [31:0]                          time_of_day_counter;
    logic [7:0]                           ctrl;
    logic [7:0]                           count;
    logic [15:0]                          period;
    logic [7:0]                           pattern;
    logic [2:0]                           pat_last;
    logic [31:0]                          tod_cmp;
    logic [31:0]                          dpll_dly;
    logic [NUM_PAIRS-1:0][`SPC_P_W-1:0]   pair;
    logic                                 sw_start;
    logic                                 sw_stop;
    logic                                 aw_full;
    logic [7:0]                           aw_q;
    logic                                 w_full;
    logic [31:0]                          w_q;
    logic [3:0]                           strb_q;
    logic                                 bvalid;
    logic [1:0]                           bresp;
    logic                                 rvalid;
    logic [1:0]                           rresp;
    logic [31:0]                          rdata;
  } spc_core_t;

  spc_core_t s;
  spc_core_t next_s;
  logic [15:0] half;
  logic        last;
  logic        rise;
  logic        fall;
  logic        hw_start;
  logic        hw_stop;
  logic        start_ev;
  logic        stop_ev;
  logic        lvl_mode;
  logic        cont;
  logic [31:0] merged;
  logic [5:0]  pidx;

  // Merge write data into an old word under the byte strobes.
  function automatic logic [31:0] spc_merge(input logic [31:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : spc_merge

  // ----------
  // Next state
  // ----------
  always_comb begin
    next_s = s;
    merged = 32'h0;
    pidx = 6'h00;
    cont = s.ctrl[`SPC_F_CONT];
    lvl_mode = s.ctrl[`SPC_F_SENSE+1];

    // SYSREF-rate clock divider; last marks the cycle before its edge.
    half = {1'b0, s.period[15:1]};
    last = (s.cnt >= s.period - 16'h0001);
    next_s.cnt = last ? 16'h0000 : s.cnt + 16'h0001;
    next_s.clk_int = (next_s.cnt < half);

    // Trigger pin synchroniser, then edge and level detection.
    next_s.sync1 = external_async_trigger;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    rise = s.sync2 & ~s.sync3;
    fall = ~s.sync2 & s.sync3;
    case (spc_sense_t'(s.ctrl[`SPC_F_SENSE +: 2]))
      SENSE_RISE: hw_start = rise;
      SENSE_FALL: hw_start = fall;
      SENSE_HIGH: hw_start = s.sync2;
      SENSE_LOW:  hw_start = ~s.sync2;
      default:    hw_start = 1'b0;
    endcase
    // Level modes stop on the inactive level, edge modes on an edge.
    if (lvl_mode) begin
      hw_stop = s.ctrl[`SPC_F_SENSE] ? s.sync2 : ~s.sync2;
    end else begin
      hw_stop = s.ctrl[`SPC_F_STOP_FALL] ? fall : rise;
    end

    // Time-of-day counter and compare event.
    next_s.time_of_day_counter = s.time_of_day_counter + 32'h0000_0001;
    start_ev = hw_start | s.sw_start |
               (s.ctrl[`SPC_F_TOD_EN] && s.time_of_day_counter == s.tod_cmp);
    stop_ev = hw_stop | s.sw_stop;
    next_s.sw_start = 1'b0;
    next_s.sw_stop = 1'b0;

    // Pending flags; the consuming cycle clears the flag and takes any new event with it.
    next_s.start_pend = (s.state == ST_IDLE) & (s.start_pend | start_ev);
    next_s.stop_pend = (s.state == ST_RUN || s.state == ST_ALIGN) & cont
                       & (s.stop_pend | stop_ev);

    // Burst sequencer; idle, align and run step only at SYSREF-rate clock edges, hold counts aclk cycles.
    case (s.state)
      ST_IDLE: begin
        if (last && (s.start_pend || start_ev)) begin
          next_s.start_pend = 1'b0;
          next_s.left = (s.count == 8'h00) ? 8'h01 : s.count;
          next_s.slot = 3'h0;
          if (s.ctrl[`SPC_F_PRIMARY]) begin
            next_s.trig_out = 1'b1;
            next_s.state = ST_ALIGN;
          end else begin
            next_s.emit = 1'b1;
            next_s.state = ST_RUN;
          end
        end
      end
      ST_ALIGN: begin
        if (last) begin
          next_s.emit = 1'b1;
          next_s.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (last) begin
          if (!cont) begin
            if (s.left == 8'h01) begin
              next_s.emit = 1'b0;
              next_s.hold = {1'b0, s.period} + {1'b0, half} - 17'h00001;
              next_s.state = ST_HOLD;
            end else begin
              next_s.left = s.left - 8'h01;
            end
          end else if (s.stop_pend || stop_ev) begin
            next_s.stop_pend = 1'b0;
            next_s.emit = 1'b0;
            next_s.trig_out = 1'b0;
            next_s.state = ST_IDLE;
          end else begin
            // Pattern slots cycle through pattern bits 0..pat_last.
            next_s.slot = (s.slot == s.pat_last) ? 3'h0
                                                 : s.slot + 3'h1;
            next_s.emit = s.ctrl[`SPC_F_PAT_EN] ?
                          s.pattern[next_s.slot] : 1'b1;
          end
        end
      end
      ST_HOLD: begin
        if (s.hold == 17'h00000) begin
          next_s.trig_out = 1'b0;
          next_s.state = ST_IDLE;
        end else begin
          next_s.hold = s.hold - 17'h00001;
        end
      end
      default: begin
        next_s.state = ST_IDLE;
      end
    endcase

    // ----------
    // AXI4-Lite slave
    // ----------
    if (awvalid && !s.aw_full) begin
      next_s.aw_full = 1'b1;
      next_s.aw_q = awaddr;
    end
    if (wvalid && !s.w_full) begin
      next_s.w_full = 1'b1;
      next_s.w_q = wdata;
      next_s.strb_q = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    // Write once both halves are held and the last answer is gone.
    if (s.aw_full && s.w_full && !s.bvalid) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `SPC_RESP_OK;
      pidx = s.aw_q[7:2] - 6'h08;
      case (s.aw_q)
        `SPC_A_CTRL: begin
          merged = spc_merge({24'h0, s.ctrl}, s.w_q, s.strb_q);
          next_s.ctrl = merged[7:0];
          next_s.sw_start = merged[`SPC_F_INIT]
                            & ~s.ctrl[`SPC_F_INIT];
          next_s.sw_stop = ~merged[`SPC_F_INIT]
                           & s.ctrl[`SPC_F_INIT];
        end
        `SPC_A_COUNT: begin
          merged = spc_merge({24'h0, s.count}, s.w_q, s.strb_q);
          next_s.count = merged[7:0];
        end
        `SPC_A_PERIOD: begin
          merged = spc_merge({16'h0, s.period}, s.w_q, s.strb_q);
          next_s.period = (merged[15:0] < `SPC_MIN_PERIOD) ?
                          `SPC_MIN_PERIOD : merged[15:0];
        end
        `SPC_A_PATTERN: begin
          merged = spc_merge({21'h0, s.pat_last, s.pattern},
                             s.w_q, s.strb_q);
          next_s.pattern = merged[7:0];
          next_s.pat_last = merged[10:8];
        end
        `SPC_A_TOD_CMP: begin
          next_s.tod_cmp = spc_merge(s.tod_cmp, s.w_q, s.strb_q);
        end
        `SPC_A_TOD, `SPC_A_STATUS: begin
          next_s.bresp = `SPC_RESP_OK;
        end
        `SPC_A_DPLL_DLY: begin
          next_s.dpll_dly = spc_merge(s.dpll_dly, s.w_q, s.strb_q);
        end
        default: begin
          if (s.aw_q >= `SPC_A_PAIR0 && 32'(pidx) < NUM_PAIRS &&
              s.aw_q[1:0] == 2'b00) begin
            merged = spc_merge({{(32-`SPC_P_W){1'b0}}, s.pair[pidx]},
                               s.w_q, s.strb_q);
            next_s.pair[pidx] = merged[`SPC_P_W-1:0];
          end else begin
            next_s.bresp = `SPC_RESP_SLVERR;
          end
        end
      endcase
    end

    // Reads answer one cycle after the address is taken.
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = `SPC_RESP_OK;
      next_s.rdata = 32'h0;
      pidx = araddr[7:2] - 6'h08;
      case (araddr)
        `SPC_A_CTRL:     next_s.rdata = {24'h0, s.ctrl};
        `SPC_A_COUNT:    next_s.rdata = {24'h0, s.count};
        `SPC_A_PERIOD:   next_s.rdata = {16'h0, s.period};
        `SPC_A_PATTERN:  next_s.rdata = {21'h0, s.pat_last, s.pattern};
        `SPC_A_TOD_CMP:  next_s.rdata = s.tod_cmp;
        `SPC_A_TOD:      next_s.rdata = s.time_of_day_counter;
        `SPC_A_STATUS:   next_s.rdata = {16'h0, s.left, 3'h0, s.emit,
                                         s.trig_out, s.start_pend,
                                         s.state};
        `SPC_A_DPLL_DLY: next_s.rdata = s.dpll_dly;
        default: begin
          if (araddr >= `SPC_A_PAIR0 && 32'(pidx) < NUM_PAIRS &&
              araddr[1:0] == 2'b00) begin
            next_s.rdata = {{(32-`SPC_P_W){1'b0}}, s.pair[pidx]};
          end else begin
            next_s.rresp = `SPC_RESP_SLVERR;
          end
        end
      endcase
    end
  end

  // ----------
  // State register
  // ----------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.state <= ST_IDLE;
      s.count <= `SPC_RST_COUNT;
      s.period <= `SPC_RST_PERIOD;
      s.pattern <= `SPC_RST_PATTERN;
      s.pat_last <= `SPC_RST_PAT_LST;
      for (int i = 0; i < NUM_PAIRS; i++) begin
        s.pair[i] <= `SPC_RST_PAIR;
      end
    end else begin
      s <= next_s;
    end
  end

  // ----------
  // Output pairs
  // ----------
  for (genvar g = 0; g < NUM_PAIRS; g++) begin : g_pair
    spc_pair_out u_pair (
      .aclk            (aclk),
      .aresetn         (aresetn),
      .enable          (s.pair[g][`SPC_P_EN]),
      .half_div        (s.pair[g][`SPC_P_HALF +: 8]),
      .shift           (s.pair[g][`SPC_P_SHIFT +: 8]),
      .dev_fine        (s.pair[g][`SPC_P_DEV_FINE +: 2]),
      .sys_fine        (s.pair[g][`SPC_P_SYS_FINE +: 2]),
      .frame_start     (s.cnt == 16'h0000),
      .sysref_run      (s.emit && s.cnt < half),
      .sysref_out      (sysref_out[g]),
      .devclk_out      (devclk_out[g]),
      .sysref_fine_dly (sysref_fine_dly[2*g +: 2]),
      .devclk_fine_dly (devclk_fine_dly[2*g +: 2])
    );
  end

  // Bus handshakes and register-driven outputs.
  assign awready          = ~s.aw_full;
  assign wready           = ~s.w_full;
  assign arready          = ~s.rvalid;
  assign bvalid           = s.bvalid;
  assign bresp            = s.bresp;
  assign rvalid           = s.rvalid;
  assign rdata            = s.rdata;
  assign rresp            = s.rresp;
  assign trigger_out      = s.trig_out;
  assign sysref_clk_int   = s.clk_int;
  assign dpll_delay_steps = s.dpll_dly;
endmodule : spc_sysref_ctrl

// ### spc_consts.svh
// Constants for the SYSREF pulse controller: offsets, fields, resets.
// Assumes byte addresses on an AXI4-Lite bus with 32-bit data.
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH

// ----------
// Register byte offsets
// ----------
`define SPC_A_CTRL      8'h00
`define SPC_A_COUNT     8'h04
`define SPC_A_PERIOD    8'h08
`define SPC_A_PATTERN   8'h0c
`define SPC_A_TOD_CMP   8'h10
`define SPC_A_TOD       8'h14
`define SPC_A_STATUS    8'h18
`define SPC_A_DPLL_DLY  8'h1c
`define SPC_A_PAIR0     8'h20

// ----------
// Control field positions
// ----------
`define SPC_F_INIT      0
`define SPC_F_CONT      1
`define SPC_F_PAT_EN    2
`define SPC_F_PRIMARY   3
`define SPC_F_SENSE     4
`define SPC_F_STOP_FALL 6
`define SPC_F_TOD_EN    7

// Pair register field positions.
`define SPC_P_EN        0
`define SPC_P_HALF      1
`define SPC_P_SHIFT     9
`define SPC_P_DEV_FINE  17
`define SPC_P_SYS_FINE  19
`define SPC_P_W         21

// ----------
// Reset values and timing
// ----------
`define SPC_RST_COUNT   8'h01
`define SPC_RST_PERIOD  16'h0010
`define SPC_MIN_PERIOD  16'h0002
`define SPC_RST_PATTERN 8'h55
`define SPC_RST_PAT_LST 3'h7
`define SPC_RST_PAIR    21'h000002
// Fine delay code n means n times this step; codes 0..2 only.
`define SPC_FINE_STEP_PS 50
// Each signed step of a DPLL delay field is this many picoseconds.
`define SPC_DPLL_STEP_PS 10
`define SPC_RESP_OK     2'b00
`define SPC_RESP_SLVERR 2'b10

`endif

// ### spc_pkg.sv
// Types shared by the SYSREF pulse controller modules.
// Assumes spc_consts.svh is on the include path.
package spc_pkg;
  // Controller states, Gray coded along idle, align, run, hold.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ALIGN = 2'b01,
    ST_RUN   = 2'b11,
    ST_HOLD  = 2'b10
  } spc_state_t;

  // Hardware start trigger sensitivity.
  typedef enum logic [1:0] {
    SENSE_RISE = 2'b00,
    SENSE_FALL = 2'b01,
    SENSE_HIGH = 2'b10,
    SENSE_LOW  = 2'b11
  } spc_sense_t;
endpackage : spc_pkg

// ### spc_pair_out.sv
// One SYSREF and device clock output pair.
// Assumes frame_start marks each SYSREF-rate clock rising edge.
module spc_pair_out
  import spc_pkg::*;
(
  // Clock and reset.
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Configuration.
  input  wire logic       enable,
  input  wire logic [7:0] half_div,
  input  wire logic [7:0] shift,
  input  wire logic [1:0] dev_fine,
  input  wire logic [1:0] sys_fine,
  // Timing from the core.
  input  wire logic       frame_start,
  input  wire logic       sysref_run,
  // Outputs.
  output logic            sysref_out,
  output logic            devclk_out,
  output logic [1:0]      sysref_fine_dly,
  output logic [1:0]      devclk_fine_dly
);
  typedef struct packed {
    logic [7:0] sdl;
    logic [7:0] hc;
    logic       dc;
    logic       sys;
    logic       dev;
    logic [1:0] sf;
    logic [1:0] df;
  } spc_pair_t;

  spc_pair_t s;
  spc_pair_t next_s;
  logic [7:0] hlim;
  logic       realign;

  // Device clock restarts high on each frame edge, delayed by shift.
  always_comb begin
    next_s = s;
    hlim = (half_div == 8'h00) ? 8'h01 : half_div;
    realign = (frame_start && shift == 8'h00) || (s.sdl == 8'h01);
    if (frame_start) begin
      next_s.sdl = shift;
    end else if (s.sdl != 8'h00) begin
      next_s.sdl = s.sdl - 8'h01;
    end
    if (realign) begin
      next_s.dc = 1'b1;
      next_s.hc = hlim - 8'h01;
    end else if (s.hc == 8'h00) begin
      next_s.dc = ~s.dc;
      next_s.hc = hlim - 8'h01;
    end else begin
      next_s.hc = s.hc - 8'h01;
    end
    next_s.sys = enable & sysref_run;
    next_s.dev = enable & next_s.dc;
    next_s.sf = sys_fine;
    next_s.df = dev_fine;
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sysref_out      = s.sys;
  assign devclk_out      = s.dev;
  assign sysref_fine_dly = s.sf;
  assign devclk_fine_dly = s.df;
endmodule : spc_pair_out

// ### spc_sysref_ctrl_props.sv
// Port checks for the SYSREF pulse controller, bound to its top module.
// Assumes PERIOD 4 and pair 0 enabled with shift 0 while pulses run.
module spc_sysref_ctrl_props #(
  parameter int NUM_PAIRS = 6
) (
  // Clock and reset.
  input wire logic                 aclk,
  input wire logic                 aresetn,
  // Bus handshakes.
  input wire logic                 awvalid,
  input wire logic                 awready,
  input wire logic                 wvalid,
  input wire logic                 wready,
  input wire logic                 bvalid,
  input wire logic                 bready,
  input wire logic                 arvalid,
  input wire logic                 arready,
  input wire logic                 rvalid,
  input wire logic                 rready,
  // Trigger and clock outputs.
  input wire logic                 trigger_out,
  input wire logic                 sysref_clk_int,
  input wire logic [NUM_PAIRS-1:0] sysref_out,
  input wire logic [NUM_PAIRS-1:0] devclk_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Checks
  // ----
  // All checks share the one clock and its reset.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_write_answer:
    assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  chk_bresp_hold:
    assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  chk_read_answer:
    assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  chk_rdata_hold:
    assert property (rvalid && !rready |=> rvalid)
    else $error("read data dropped");
  chk_no_runt:
    assert property ($rose(sysref_out[0]) |-> sysref_out[0] [*2])
    else $error("short pulse");
  chk_pulse_frame:
    assert property ($rose(sysref_out[0]) |-> sysref_clk_int)
    else $error("pulse off frame");
  chk_dev_align:
    assert property ($rose(sysref_out[0]) |-> $rose(devclk_out[0]))
    else $error("device clock not aligned");
  chk_start_order:
    assert property ($rose(trigger_out) |->
                     !sysref_out[0] [*4] ##[1:2] sysref_out[0])
    else $error("start not one frame after trigger");
  chk_stop_clean:
    assert property ($fell(trigger_out) |-> !sysref_out[0] [*4])
    else $error("pulse after trigger drop");

  // Main scenarios reached.
  cover property ($rose(sysref_out[0]));
  cover property ($fell(trigger_out));
  cover property (rvalid && rready);
endmodule : spc_sysref_ctrl_props

// ### spc_conv_model.sv
// Converter model that counts SYSREF pulses on pair 0.
// Assumes SYSREF arrives on the controller clock.
module spc_conv_model (
  // Clock and reset.
  input  wire logic   aclk,
  input  wire logic   aresetn,
  // SYSREF from the controller.
  input  wire logic   sysref,
  // Pulse count and cycles since the last pulse.
  output logic [15:0] pulses,
  output logic [15:0] since
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev;
  // Marks a frame at each SYSREF rising edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev   <= 1'b0;
      pulses <= 16'h0000;
      since  <= 16'h0000;
    end else begin
      prev   <= sysref;
      pulses <= pulses + 16'(sysref & !prev);
      since  <= (sysref & !prev) ? 16'h0000 : since + 16'h0001;
    end
  end
endmodule : spc_conv_model

// ### tb.sv
// Self-checking bench for the SYSREF pulse controller.
// Assumes the controller, checker and converter model compile first.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        external_async_trigger = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awready, wready, bvalid, arready, rvalid, trigger_out, sclk;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rv, dly;
  logic [5:0]  sysref_out, devclk_out;
  logic [15:0] pulses, since, p0;
  int          err_total = 0;
  int          n_tests = 0;

  spc_sysref_ctrl #(.NUM_PAIRS(6)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .external_async_trigger(external_async_trigger),
    .trigger_out(trigger_out), .sysref_clk_int(sclk),
    .sysref_out(sysref_out), .devclk_out(devclk_out),
    .sysref_fine_dly(), .devclk_fine_dly(), .dpll_delay_steps(dly));
  spc_conv_model i_conv (.aclk(aclk), .aresetn(aresetn),
    .sysref(sysref_out[0]), .pulses(pulses), .since(since));

  // Makes the 200 MHz clock.
  always #2.5 aclk = ~aclk;

  // Counts a compare and reports a mismatch.
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask : chk

  // One register write; the response lands in resp.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  // One register read into rv and resp.
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rv = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  // Waits, bounded, for the trigger output to reach a level.
  task automatic wait_trig(input logic l);
    for (int i = 0; i < 1200 && trigger_out !== l; i++) @(posedge aclk);
  endtask : wait_trig

  // Lets output settle, then checks whether pulses still come.
  task automatic run_chk(input logic e);
    repeat (16) @(posedge aclk);
    p0 = pulses;
    repeat (20) @(posedge aclk);
    chk(pulses != p0, e, "running");
  endtask : run_chk

  // Reset values, bus errors and the pulse setup used later.
  task automatic t_regs();
    rd(8'h04); chk(rv, 32'h1, "count");
    rd(8'h0c); chk(rv, 32'h755, "pattern");
    rd(8'h34); chk(rv, 32'h2, "last pair");
    rd(8'h38); chk(resp, 2'b10, "bad read");
    wr(8'h38, 32'h1); chk(resp, 2'b10, "bad write");
    wr(8'h08, 32'h4);
    wr(8'h20, 32'h5);
    rd(8'h08); chk(rv, 32'h4, "period");
    wr(8'h1c, 32'h0a0b0c0d);
    chk(dly, 32'h0a0b0c0d, "dpll delay");
  endtask : t_regs

  // Software started bursts of one and of 255 pulses as primary.
  task automatic t_counted();
    logic [7:0] n;
    for (int k = 0; k < 2; k++) begin
      n = k ? 8'hff : 8'h01;
      wr(8'h04, {24'h0, n});
      p0 = pulses;
      wr(8'h00, 32'h9);
      wait_trig(1'b1);
      wait_trig(1'b0);
      chk(pulses - p0, {24'h0, n}, "burst");
      chk(since >= 16'd7 && since <= 16'd9, 1'b1, "ready");
      wr(8'h00, 32'h8);
    end
  endtask : t_counted

  // Time of day match starts a burst of two.
  task automatic t_tod();
    wr(8'h04, 32'h2);
    rd(8'h14);
    wr(8'h10, rv + 32'd80);
    p0 = pulses;
    wr(8'h00, 32'h80);
    repeat (160) @(posedge aclk);
    chk(pulses - p0, 32'h2, "tod burst");
    wr(8'h00, 32'h0);
  endtask : t_tod

  // Steady train, then pattern, each stopped by software.
  task automatic t_cont();
    logic [15:0] p;
    wr(8'h0c, 32'h305);
    for (int k = 0; k < 2; k++) begin
      p = pulses;
      wr(8'h00, k ? 32'h7 : 32'h3);
      for (int i = 0; i < 100 && pulses === p; i++) @(posedge aclk);
      p = pulses;
      repeat (40) @(posedge aclk);
      chk(pulses - p, k ? 32'd5 : 32'd10, "train");
      wr(8'h00, k ? 32'h6 : 32'h2);
      run_chk(1'b0);
    end
  endtask : t_cont

  // Pin edge start and stop, rising then falling.
  task automatic t_pin();
    logic idle;
    for (int k = 0; k < 2; k++) begin
      idle = k[0];
      wr(8'h00, k ? 32'h52 : 32'h02);
      @(posedge aclk) external_async_trigger <= !idle;
      run_chk(1'b1);
      @(posedge aclk) external_async_trigger <= idle;
      run_chk(1'b1);
      @(posedge aclk) external_async_trigger <= !idle;
      run_chk(1'b0);
    end
  endtask : t_pin

  // Level starts as primary; the trigger output follows the pin.
  task automatic t_level();
    logic act;
    for (int k = 0; k < 2; k++) begin
      act = !k[0];
      wr(8'h00, k ? 32'h3a : 32'h2a);
      @(posedge aclk) external_async_trigger <= act;
      run_chk(1'b1);
      chk(trigger_out, 1'b1, "trig high");
      @(posedge aclk) external_async_trigger <= !act;
      run_chk(1'b0);
      chk(trigger_out, 1'b0, "trig low");
    end
  endtask : t_level

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("compares %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // Holds reset for 20 cycles, then runs each scenario.
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_counted();
    t_tod();
    t_cont();
    t_pin();
    t_level();
    complete_run();
  end

  // Cuts a hang short well after the expected run length.
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    complete_run();
  end
endmodule : tb

bind spc_sysref_ctrl spc_sysref_ctrl_props #(.NUM_PAIRS(NUM_PAIRS)) i_chk (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .trigger_out(trigger_out), .sysref_clk_int(sysref_clk_int),
  .sysref_out(sysref_out), .devclk_out(devclk_out));
